/* File: src/tcs_pkg.sv */
// constants, encodings and timing figures for the time code sync receiver
// What this block does
// [RQ1] The time code pin takes an unmodulated pulse-width coded 5V level signal from the clock.
// [RQ2] Only code designations B000, B001, B004 and B005 are decoded; others are unsupported.
// [RQ3] A designation is one format letter and three decimal identification digits.
// [RQ4] First digit 0 means DC level shift with no carrier; carrier and Manchester are refused.
// [RQ5] Third digit picks frame content: 0 full, 1 no binary seconds, 4 adds year, 5 year no SBS.
// [RQ6] A minute-aligned pulse on one selected digital input of 48 may serve as the source.
// [RQ7] Exactly one configured source (time code, input pulse, network time) is followed.
// [RQ8] A time code fault is intermittent and clears itself once the signal recovers.
// [RQ9] The global fault flag stays high while any non-critical fault is present.
// [RQ10] Bits arrive at 100 per second; pulse widths are timed against the 10 ms interval.
package tcs_pkg;
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned TICK_TIME_US     = 100;
  localparam int unsigned TICK_CYCLES_DFLT = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BIT_INTERVAL_MS  = 10;
  localparam int unsigned BIT_TICKS        = BIT_INTERVAL_MS * 1000 / TICK_TIME_US;
  // pulse width windows in ticks (nominal 2, 5 and 8 ms)
  localparam logic [8:0] ZERO_MIN  = 9'h00_0A;
  localparam logic [8:0] ZERO_MAX  = 9'h00_23;
  localparam logic [8:0] ONE_MAX   = 9'h00_41;
  localparam logic [8:0] MARK_MAX  = 9'h00_5F;
  // three bit intervals with no rising edge means the signal is lost
  localparam logic [8:0] LOSS_TICKS = 9'(3 * BIT_TICKS);
  // symbol codes
  localparam logic [1:0] SYM_ZERO = 2'h0;
  localparam logic [1:0] SYM_ONE  = 2'h1;
  localparam logic [1:0] SYM_MARK = 2'h2;
  localparam logic [1:0] SYM_BAD  = 2'h3;
  // frame layout
  localparam logic [6:0] FRAME_LAST = 7'h63;
  localparam logic [3:0] MARK_SLOT  = 4'h9;
  // designation
  localparam logic [7:0] FMT_LETTER_B = 8'h42;
  localparam logic [3:0] DIG_ZERO     = 4'h0;
  localparam logic [3:0] CONT_FULL    = 4'h0;
  localparam logic [3:0] CONT_NO_SBS  = 4'h1;
  localparam logic [3:0] CONT_YEAR    = 4'h4;
  localparam logic [3:0] CONT_YEAR_NS = 4'h5;
  // sources
  localparam logic [1:0] SRC_IRIG = 2'h0;
  localparam logic [1:0] SRC_DI   = 2'h1;
  localparam logic [1:0] SRC_SNTP = 2'h2;
  localparam int unsigned DI_COUNT = 48;
  // frame states
  typedef enum logic [2:0] {
    ST_HUNT  = 3'b001,
    ST_SYNC  = 3'b010,
    ST_FRAME = 3'b100
  } tcs_state_t;
endpackage

/* File: src/tcs_pulse_if.sv */
// link between the frame decoder and the pulse width classifier
`timescale 1ns/100ps
interface tcs_pulse_if;
  logic       level;
  logic       tick;
  logic       sym_valid;
  logic [1:0] sym;
  logic       lost;
  modport dec (output level, output tick, input sym_valid, input sym, input lost);
  modport cls (input level, input tick, output sym_valid, output sym, output lost);
endinterface

/* File: src/tcs_pulse_classifier.sv */
// measures high pulse widths on the time code line and classifies them
`timescale 1ns/100ps
module tcs_pulse_classifier (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // decoder side
  tcs_pulse_if.cls  pif
);
  logic       prev_ff,  nxt_prev;
  logic [8:0] width_ff, nxt_width;
  logic [8:0] idle_ff,  nxt_idle;
  logic       valid_ff, nxt_valid;
  logic [1:0] sym_ff,   nxt_sym;
  logic       lost_ff,  nxt_lost;

  // width and idle counters saturate so a stuck line cannot wrap into a good width
  always_comb begin
    nxt_prev  = pif.level;
    nxt_width = width_ff;
    nxt_idle  = idle_ff;
    nxt_valid = 1'b0;
    nxt_sym   = sym_ff;
    nxt_lost  = lost_ff;
    if (pif.tick && pif.level && width_ff != 9'h1_FF) nxt_width = width_ff + 9'h0_01;
    if (pif.tick && idle_ff != 9'h1_FF) nxt_idle = idle_ff + 9'h0_01;
    if (pif.level && !prev_ff) begin
      nxt_width = 9'h0_00;
      nxt_idle  = 9'h0_00;
      nxt_lost  = 1'b0;
    end
    // [RQ10] width against interval
    if (prev_ff && !pif.level) begin
      nxt_valid = 1'b1;
      if (width_ff < tcs_pkg::ZERO_MIN)       nxt_sym = tcs_pkg::SYM_BAD;
      else if (width_ff <= tcs_pkg::ZERO_MAX) nxt_sym = tcs_pkg::SYM_ZERO;
      else if (width_ff <= tcs_pkg::ONE_MAX)  nxt_sym = tcs_pkg::SYM_ONE;
      else if (width_ff <= tcs_pkg::MARK_MAX) nxt_sym = tcs_pkg::SYM_MARK;
      else                                    nxt_sym = tcs_pkg::SYM_BAD;
    end
    // judged on the next idle count, so a fresh rising edge ends a loss instead of
    // leaving it latched by the stale saturated count
    if (nxt_idle >= tcs_pkg::LOSS_TICKS) nxt_lost = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_ff  <= 1'b0;
      width_ff <= 9'h0_00;
      idle_ff  <= 9'h0_00;
      valid_ff <= 1'b0;
      sym_ff   <= tcs_pkg::SYM_BAD;
      lost_ff  <= 1'b1;
    end else begin
      prev_ff  <= nxt_prev;
      width_ff <= nxt_width;
      idle_ff  <= nxt_idle;
      valid_ff <= nxt_valid;
      sym_ff   <= nxt_sym;
      lost_ff  <= nxt_lost;
    end
  end

  assign pif.sym_valid = valid_ff;
  assign pif.sym       = sym_ff;
  assign pif.lost      = lost_ff;

  // every falling edge of the level line yields one symbol
  AST_FALL_GIVES_SYMBOL: assert property (@(posedge mclk) disable iff (reset) // [RQ1]
    (prev_ff && !pif.level) |=> pif.sym_valid)
    else $error("falling edge gave no symbol");

  // a marker symbol only follows a width inside the marker window
  AST_MARK_WIDTH: assert property (@(posedge mclk) disable iff (reset) // [RQ10]
    (pif.sym_valid && pif.sym == tcs_pkg::SYM_MARK) |->
      ($past(width_ff) > tcs_pkg::ONE_MAX && $past(width_ff) <= tcs_pkg::MARK_MAX))
    else $error("marker symbol from wrong width");
endmodule

/* File: src/tcs_receiver.sv */
// time code sync receiver top: source select, frame decode, fault flags
`timescale 1ns/100ps
module tcs_receiver #(
  parameter int unsigned TICK_CYCLES = tcs_pkg::TICK_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // external time sources
  input  wire logic        irig_in,
  input  wire logic [47:0] di_in,
  input  wire logic        sntp_sync,
  // configuration and non-critical fault input
  input  wire logic [1:0]  src_sel,
  input  wire logic [5:0]  di_sel,
  input  wire logic [7:0]  code_letter,
  input  wire logic [3:0]  code_dig1,
  input  wire logic [3:0]  code_dig2,
  input  wire logic [3:0]  code_dig3,
  input  wire logic        nc_fault_in,
  // decoded time
  output logic             time_valid,
  output logic [6:0]       sec_bcd,
  output logic [6:0]       min_bcd,
  output logic [5:0]       hour_bcd,
  output logic [9:0]       day_bcd,
  output logic [7:0]       year_bcd,
  output logic [16:0]      sbs,
  // status
  output logic             sync_pulse,
  output logic             code_ok,
  output logic             has_year,
  output logic             has_sbs,
  output logic             irig_fault,
  output logic             device_fault
);
  tcs_pulse_if pif ();

  tcs_pulse_classifier u_cls (
    .mclk  (mclk),
    .reset (reset),
    .pif   (pif)
  );

  function automatic logic is_dec(input logic [3:0] d);
    return d <= 4'h9;
  endfunction

  // tick divider and pin synchronisers
  logic [12:0] div_ff, nxt_div;
  logic        tick_ff, nxt_tick;
  logic        irig_meta_ff, irig_sync_ff;
  logic        di_meta_ff, di_sync_ff, di_prev_ff;
  logic        di_raw;

  assign di_raw = (32'(di_sel) < tcs_pkg::DI_COUNT) ? di_in[di_sel] : 1'b0;

  always_comb begin
    nxt_tick = 1'b0;
    nxt_div  = div_ff + 13'h0_001;
    if (div_ff == 13'(TICK_CYCLES - 1)) begin
      nxt_div  = 13'h0_000;
      nxt_tick = 1'b1;
    end
  end

  // the selected input is muxed before syncing; a select change may give one stray edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_ff       <= 13'h0_000;
      tick_ff      <= 1'b0;
      irig_meta_ff <= 1'b0;
      irig_sync_ff <= 1'b0;
      di_meta_ff   <= 1'b0;
      di_sync_ff   <= 1'b0;
      di_prev_ff   <= 1'b0;
    end else begin
      div_ff       <= nxt_div;
      tick_ff      <= nxt_tick;
      irig_meta_ff <= irig_in;
      irig_sync_ff <= irig_meta_ff;
      di_meta_ff   <= di_raw;
      di_sync_ff   <= di_meta_ff;
      di_prev_ff   <= di_sync_ff;
    end
  end

  assign pif.level = irig_sync_ff;
  assign pif.tick  = tick_ff;

  // designation check
  logic ok_ff, nxt_ok, year_ff, nxt_year, sbs_ff, nxt_sbs;

  always_comb begin
    // [RQ3] letter plus digits
    nxt_ok = code_letter == tcs_pkg::FMT_LETTER_B && is_dec(code_dig1)
             && is_dec(code_dig2) && is_dec(code_dig3);
    // [RQ4] dc level shift only
    nxt_ok = nxt_ok && code_dig1 == tcs_pkg::DIG_ZERO && code_dig2 == tcs_pkg::DIG_ZERO;
    // [RQ2] supported variants only
    nxt_ok = nxt_ok && (code_dig3 == tcs_pkg::CONT_FULL || code_dig3 == tcs_pkg::CONT_NO_SBS
             || code_dig3 == tcs_pkg::CONT_YEAR || code_dig3 == tcs_pkg::CONT_YEAR_NS);
    // [RQ5] content flags
    nxt_year = code_dig3 == tcs_pkg::CONT_YEAR || code_dig3 == tcs_pkg::CONT_YEAR_NS;
    nxt_sbs  = code_dig3 == tcs_pkg::CONT_FULL || code_dig3 == tcs_pkg::CONT_YEAR;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ok_ff   <= 1'b0;
      year_ff <= 1'b0;
      sbs_ff  <= 1'b0;
    end else begin
      ok_ff   <= nxt_ok;
      year_ff <= nxt_year;
      sbs_ff  <= nxt_sbs;
    end
  end

  // frame decoder: two markers in a row mark the frame start
  tcs_pkg::tcs_state_t state_ff, nxt_state;
  logic [6:0]  idx_ff, nxt_idx;
  logic [3:0]  slot_ff, nxt_slot;
  logic [99:0] bits_ff, nxt_bits;
  logic        frame_done, frame_err;

  always_comb begin
    nxt_state  = state_ff;
    nxt_idx    = idx_ff;
    nxt_slot   = slot_ff;
    nxt_bits   = bits_ff;
    frame_done = 1'b0;
    frame_err  = 1'b0;
    if (pif.sym_valid) begin
      unique case (state_ff)
        tcs_pkg::ST_HUNT: begin
          if (pif.sym == tcs_pkg::SYM_MARK) nxt_state = tcs_pkg::ST_SYNC;
        end
        tcs_pkg::ST_SYNC: begin
          nxt_idx   = 7'h01;
          nxt_slot  = 4'h1;
          nxt_state = (pif.sym == tcs_pkg::SYM_MARK) ? tcs_pkg::ST_FRAME : tcs_pkg::ST_HUNT;
        end
        tcs_pkg::ST_FRAME: begin
          // markers sit only at every tenth position
          if (pif.sym == tcs_pkg::SYM_BAD
              || ((slot_ff == tcs_pkg::MARK_SLOT) != (pif.sym == tcs_pkg::SYM_MARK))) begin
            frame_err = 1'b1;
            nxt_state = tcs_pkg::ST_HUNT;
          end else begin
            nxt_bits[idx_ff] = pif.sym == tcs_pkg::SYM_ONE;
            nxt_idx          = idx_ff + 7'h01;
            nxt_slot         = (slot_ff == tcs_pkg::MARK_SLOT) ? 4'h0 : slot_ff + 4'h1;
            if (idx_ff == tcs_pkg::FRAME_LAST) begin
              frame_done = 1'b1;
              nxt_state  = tcs_pkg::ST_SYNC;
            end
          end
        end
        default: nxt_state = tcs_pkg::ST_HUNT;
      endcase
    end
    if (pif.lost) nxt_state = tcs_pkg::ST_HUNT;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= tcs_pkg::ST_HUNT;
      idx_ff   <= 7'h00;
      slot_ff  <= 4'h0;
      bits_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      slot_ff  <= nxt_slot;
      bits_ff  <= nxt_bits;
    end
  end

  // output registers, time fields and fault flags
  logic        tv_ff, nxt_tv, sp_ff, nxt_sp, flt_ff, nxt_flt, dev_ff, nxt_dev;
  logic [6:0]  sec_ff, nxt_sec, min_ff, nxt_min;
  logic [5:0]  hour_ff, nxt_hour;
  logic [9:0]  day_ff, nxt_day;
  logic [7:0]  yr_ff, nxt_yr;
  logic [16:0] sbsv_ff, nxt_sbsv;
  logic        flt_set, flt_clr;

  always_comb begin
    nxt_tv   = frame_done && ok_ff;
    nxt_sec  = sec_ff;
    nxt_min  = min_ff;
    nxt_hour = hour_ff;
    nxt_day  = day_ff;
    nxt_yr   = yr_ff;
    nxt_sbsv = sbsv_ff;
    if (nxt_tv) begin
      nxt_sec  = {nxt_bits[8:6], nxt_bits[4:1]};
      nxt_min  = {nxt_bits[17:15], nxt_bits[13:10]};
      nxt_hour = {nxt_bits[26:25], nxt_bits[23:20]};
      nxt_day  = {nxt_bits[41:40], nxt_bits[38:35], nxt_bits[33:30]};
      // [RQ5] unused fields read zero
      nxt_yr   = year_ff ? {nxt_bits[58:55], nxt_bits[53:50]} : 8'h00;
      nxt_sbsv = sbs_ff ? {nxt_bits[97:90], nxt_bits[88:80]} : 17'h0_0000;
    end
    // [RQ7] single source
    unique case (src_sel)
      tcs_pkg::SRC_IRIG: nxt_sp = nxt_tv;
      // [RQ6] input minute pulse
      tcs_pkg::SRC_DI:   nxt_sp = di_sync_ff && !di_prev_ff;
      tcs_pkg::SRC_SNTP: nxt_sp = sntp_sync;
      default:           nxt_sp = 1'b0;
    endcase
    // [RQ8] self clearing fault, set wins
    flt_set = src_sel == tcs_pkg::SRC_IRIG && (pif.lost || frame_err || !ok_ff);
    flt_clr = src_sel != tcs_pkg::SRC_IRIG || nxt_tv;
    nxt_flt = flt_set ? 1'b1 : (flt_clr ? 1'b0 : flt_ff);
    // [RQ9] global fault flag
    nxt_dev = flt_ff || nc_fault_in;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tv_ff   <= 1'b0;
      sp_ff   <= 1'b0;
      flt_ff  <= 1'b0;
      dev_ff  <= 1'b0;
      sec_ff  <= 7'h00;
      min_ff  <= 7'h00;
      hour_ff <= 6'h00;
      day_ff  <= 10'h000;
      yr_ff   <= 8'h00;
      sbsv_ff <= 17'h0_0000;
    end else begin
      tv_ff   <= nxt_tv;
      sp_ff   <= nxt_sp;
      flt_ff  <= nxt_flt;
      dev_ff  <= nxt_dev;
      sec_ff  <= nxt_sec;
      min_ff  <= nxt_min;
      hour_ff <= nxt_hour;
      day_ff  <= nxt_day;
      yr_ff   <= nxt_yr;
      sbsv_ff <= nxt_sbsv;
    end
  end

  assign time_valid   = tv_ff;
  assign sec_bcd      = sec_ff;
  assign min_bcd      = min_ff;
  assign hour_bcd     = hour_ff;
  assign day_bcd      = day_ff;
  assign year_bcd     = yr_ff;
  assign sbs          = sbsv_ff;
  assign sync_pulse   = sp_ff;
  assign code_ok      = ok_ff;
  assign has_year     = year_ff;
  assign has_sbs      = sbs_ff;
  assign irig_fault   = flt_ff;
  assign device_fault = dev_ff;

  AST_UNSUPPORTED_FAULTS: assert property (@(posedge mclk) disable iff (reset) // [RQ2]
    (src_sel == tcs_pkg::SRC_IRIG && !ok_ff) |=> irig_fault)
    else $error("unsupported code did not raise fault");

  AST_CARRIER_REFUSED: assert property (@(posedge mclk) disable iff (reset) // [RQ4]
    (code_dig1 != tcs_pkg::DIG_ZERO) |=> !code_ok)
    else $error("modulated code accepted");

  AST_NO_YEAR_ZERO: assert property (@(posedge mclk) disable iff (reset) // [RQ5]
    (time_valid && !has_year) |-> year_bcd == 8'h00)
    else $error("year shown without year content");

  AST_DI_PULSE: assert property (@(posedge mclk) disable iff (reset) // [RQ6]
    (src_sel == tcs_pkg::SRC_DI && di_sync_ff && !di_prev_ff) |=> sync_pulse)
    else $error("input minute pulse lost");

  AST_SNTP_ONLY_SELECTED: assert property (@(posedge mclk) disable iff (reset) // [RQ7]
    (src_sel != tcs_pkg::SRC_SNTP && src_sel != tcs_pkg::SRC_DI && !nxt_tv) |=> !sync_pulse)
    else $error("sync pulse from unselected source");

  AST_FAULT_AUTOCLEAR: assert property (@(posedge mclk) disable iff (reset) // [RQ8]
    (src_sel == tcs_pkg::SRC_IRIG && nxt_tv && !pif.lost) ##1 (src_sel != tcs_pkg::SRC_IRIG
      || !flt_set) |=> !irig_fault)
    else $error("time code fault did not clear");

  AST_GLOBAL_FAULT: assert property (@(posedge mclk) disable iff (reset) // [RQ9]
    (irig_fault || nc_fault_in) |=> device_fault)
    else $error("global fault flag missing");

  AST_FRAME_ERROR_HUNTS: assert property (@(posedge mclk) disable iff (reset) // [RQ10]
    frame_err |=> (state_ff == tcs_pkg::ST_HUNT) ##1 !time_valid)
    else $error("frame error did not restart hunt");
endmodule

/* File: verification/tcs_irig_source.sv */
// model of the satellite clock time code output
`timescale 1ns/100ps
module tcs_irig_source #(
  parameter int unsigned TICK_CYCLES = 2
) (
  // clock
  input  wire logic mclk,
  // time code line
  output logic      irig_out
);
  // nominal high widths in ticks: zero, one, marker
  localparam int unsigned W_ZERO = 20;
  localparam int unsigned W_ONE  = 50;
  localparam int unsigned W_MARK = 80;

  // line idles low, so no edges reach the receiver while no bit is being sent
  initial irig_out = 1'b0;

  // level coded pulse, one bit per index interval
  task automatic send_bit(input int unsigned hi_ticks);
    for (int n = 0; n < tcs_pkg::BIT_TICKS * TICK_CYCLES; n++) begin
      @(posedge mclk);
      irig_out <= (n < hi_ticks * TICK_CYCLES);
    end
  endtask

  // markers at slot 0 and every tenth slot ending in 9
  task automatic send_frame(input logic [99:0] b);
    for (int p = 0; p < 100; p++) begin
      if (p == 0 || p % 10 == 9)
        send_bit(W_MARK);
      else
        send_bit(b[p] ? W_ONE : W_ZERO);
    end
  endtask
endmodule

/* File: verification/test_tcs_receiver.sv */
// self-checking bench for the time code sync receiver
`timescale 1ns/100ps
module test_tcs_receiver;
  // one-cycle tick keeps five full frames well inside the run limit
  localparam int unsigned TC = 1;
  logic        mclk, reset, irig_in, sntp_sync, nc_fault_in;
  logic        time_valid, sync_pulse, code_ok, has_year, has_sbs;
  logic        irig_fault, device_fault;
  logic [47:0] di_in;
  logic [1:0]  src_sel;
  logic [5:0]  di_sel, s;
  logic [7:0]  code_letter, year_bcd;
  logic [3:0]  code_dig1, code_dig2, code_dig3;
  logic [6:0]  sec_bcd, min_bcd;
  logic [5:0]  hour_bcd;
  logic [9:0]  day_bcd;
  logic [16:0] sbs;
  logic [16:0] got [6];
  int          n_errors = 0, samples_checked = 0;
  int          n_valid = 0, n_sync = 0, cyc = 0, n0;

  tcs_receiver #(.TICK_CYCLES(TC)) uut (.mclk, .reset, .irig_in, .di_in, .sntp_sync,
    .src_sel, .di_sel, .code_letter, .code_dig1, .code_dig2, .code_dig3,
    .nc_fault_in, .time_valid, .sec_bcd, .min_bcd, .hour_bcd, .day_bcd, .year_bcd,
    .sbs, .sync_pulse, .code_ok, .has_year, .has_sbs, .irig_fault, .device_fault);
  tcs_irig_source #(.TICK_CYCLES(TC)) src (.mclk(mclk), .irig_out(irig_in));

  // clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // capture decoded time, count pulses, cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sync_pulse === 1'b1) n_sync <= n_sync + 1;
    if (time_valid === 1'b1) begin
      n_valid <= n_valid + 1;
      got <= '{17'(sec_bcd), 17'(min_bcd), 17'(hour_bcd), 17'(day_bcd),
               17'(year_bcd), sbs};
    end
    if (cyc >= 60000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk_bit(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %b want %b", $time, m, g, e);
    end
  endtask

  task automatic chk_val(input logic [16:0] g, input logic [16:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  task automatic results();
    $display("mismatches %0d compares %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // expected field k from the frame bits; year and sbs depend on content digit
  function automatic logic [16:0] fld(input logic [99:0] b, input int k, input logic [3:0] d);
    case (k)
      0: fld = 17'({b[8:6], b[4:1]});
      1: fld = 17'({b[17:15], b[13:10]});
      2: fld = 17'({b[26:25], b[23:20]});
      3: fld = 17'({b[41:40], b[38:35], b[33:30]});
      4: fld = (d == 4'h4 || d == 4'h5) ? 17'({b[58:55], b[53:50]}) : 17'h0_0000;
      default: fld = (d == 4'h0 || d == 4'h4) ? {b[97:90], b[88:80]} : 17'h0_0000;
    endcase
  endfunction

  // one full random frame, then compare what came out
  task automatic frame(input logic [3:0] d);
    logic [99:0] b;
    int          v0;
    b = 100'({$urandom, $urandom, $urandom, $urandom});
    v0 = n_valid;
    n0 = n_sync;
    code_dig3 <= d;
    src.send_frame(b);
    chk_val(17'(n_valid - v0), 17'h0_0001, "frame count");
    chk_val(17'(n_sync - n0), 17'h0_0001, "code sync");
    for (int k = 0; k < 6; k++) begin
      chk_val(got[k], fld(b, k, d), "field");
    end
    chk_bit(irig_fault, 1'b0, "fault clear");
    chk_bit(device_fault, 1'b0, "global clear");
  endtask

  initial begin
    void'($urandom(30));
    {reset, sntp_sync, nc_fault_in, src_sel, di_sel, di_in} = {1'b1, 58'h0};
    {code_letter, code_dig1, code_dig2, code_dig3} = {8'h42, 12'h000};
    repeat (5) @(posedge mclk);
    #1 chk_bit(irig_fault | device_fault | time_valid | sync_pulse, 1'b0, "reset");
    @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk_bit(irig_fault, 1'b1, "lost at start");
    // designation table, then random designations
    for (int i = 0; i < 30; i++) begin
      @(posedge mclk);
      code_letter <= (i == 12) ? 8'h41 : 8'h42;
      if (i > 12) begin
        code_dig1 <= 4'($urandom_range(1, 0));
        code_dig2 <= 4'($urandom_range(1, 0));
        code_dig3 <= 4'($urandom_range(15, 0));
      end else begin
        code_dig1 <= (i == 8) ? 4'h1 : (i == 9) ? 4'h2 : 4'h0;
        code_dig2 <= (i == 10) ? 4'h1 : (i == 11) ? 4'h4 : 4'h0;
        code_dig3 <= (i < 8) ? 4'(i) : 4'h0;
      end
      @(posedge mclk);
      #1 chk_bit(code_ok, code_letter == 8'h42 && {code_dig1, code_dig2} == 8'h00
        && code_dig3 inside {4'h0, 4'h1, 4'h4, 4'h5}, "code ok");
      if (code_ok === 1'b1) begin
        chk_bit(has_year, code_dig3 inside {4'h4, 4'h5}, "year");
        chk_bit(has_sbs, code_dig3 inside {4'h0, 4'h4}, "sbs");
      end
    end
    // digital input minute pulse
    s = 6'($urandom_range(47, 0));
    @(posedge mclk);
    src_sel <= tcs_pkg::SRC_DI;
    di_sel <= s;
    di_in <= 48'({$urandom, $urandom}) & ~(48'h1 << s);
    repeat (3) @(posedge mclk);
    #1 chk_bit(irig_fault, 1'b0, "fault off src");
    @(posedge mclk);
    // contact closes on the selected input
    di_in[s] <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk_bit(sync_pulse, 1'b1, "di pulse");
    @(posedge mclk);
    #1 chk_bit(sync_pulse, 1'b0, "di pulse end");
    // network time, and sources that are not selected
    @(posedge mclk);
    src_sel <= tcs_pkg::SRC_SNTP;
    di_in[s] <= 1'b0;
    nc_fault_in <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk_bit(device_fault, 1'b1, "other fault");
    @(posedge mclk);
    sntp_sync <= 1'b1;
    @(posedge mclk);
    sntp_sync <= 1'b0;
    #1 chk_bit(sync_pulse, 1'b1, "sntp pulse");
    @(posedge mclk);
    di_in[s] <= 1'b1;
    nc_fault_in <= 1'b0;
    // taken after the network pulse has been counted
    #1 n0 = n_sync;
    repeat (8) @(posedge mclk);
    src_sel <= tcs_pkg::SRC_IRIG;
    sntp_sync <= 1'b1;
    @(posedge mclk);
    sntp_sync <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk_val(17'(n_sync - n0), 17'h0_0000, "unselected");
    chk_bit(device_fault, 1'b1, "global follows");
    // time code frames, a bad pulse inside a frame, then loss of signal
    {code_dig1, code_dig2, code_dig3} <= 12'h000;
    src.send_bit(80);
    frame(4'h0);
    frame(4'h1);
    // the position 0 marker puts the decoder in frame, so a short pulse is a framing error
    src.send_bit(80);
    src.send_bit(5);
    #1 chk_bit(irig_fault, 1'b1, "bad width");
    src.send_bit(80);
    frame(4'h4);
    frame(4'h5);
    repeat (150) @(posedge mclk);
    #1 chk_bit(irig_fault, 1'b0, "before loss");
    for (int w = 0; w < 80 && irig_fault !== 1'b1; w++) @(posedge mclk);
    #1 chk_bit(irig_fault, 1'b1, "loss");
    @(posedge mclk);
    #1 chk_bit(device_fault, 1'b1, "global loss");
    // signal returns: the fault must clear by itself with the next good frame
    src.send_bit(80);
    frame(4'h0);
    results();
  end
endmodule
